// ---- verilog/cmd_err_checker.v ----
`timescale 1ns/1ps
`include "err_queue_regs.vh"
module cmd_err_checker (
  input  wire        mclk_in,          // 100 MHz clock
  input  wire        rst_n_in,         // Power-up reset, active low
  input  wire        clear_status_in,  // Clear-status command pulse
  input  wire        reset_cmd_in,     // Reset command pulse
  input  wire        query_in,         // Error query pulse
  input  wire        fault_in,         // Parser fault pulse
  input  wire [4:0]  fault_class_in,   // Parser fault class
  input  wire [3:0]  expr_sub_in,      // Expression fault index 0..8
  input  wire        hdr_chk_in,       // Header keyword check pulse
  input  wire [7:0]  kw_len_in,        // Longest keyword length
  input  wire        kw_known_in,      // Keyword recognised
  input  wire        num_chk_in,       // Numeric parameter check pulse
  input  wire [15:0] exp_mag_in,       // Exponent magnitude
  input  wire [8:0]  digits_in,        // Mantissa digits less leading zeros
  input  wire        par_chk_in,       // Parameter count check pulse
  input  wire [3:0]  par_got_in,       // Parameters received
  input  wire [3:0]  par_min_in,       // Parameters required
  input  wire [3:0]  par_max_in,       // Parameters accepted
  input  wire        blk_end_in,       // Block download ended pulse
  input  wire        blk_definite_in,  // Block was definite length
  input  wire [15:0] blk_decl_in,      // Declared byte count
  input  wire [15:0] blk_got_in,       // Bytes received
  input  wire        blk_eoi_nl_in,    // EOI came with newline
  input  wire        trig_in,          // Bus or trigger command pulse
  input  wire        trig_bus_sel_in,  // Bus trigger source selected
  input  wire        set_chk_in,       // Settings changed pulse
  input  wire [1:0]  func_in,          // Selected function
  input  wire [31:0] freq_in,          // Output frequency, Hz
  input  wire [6:0]  duty_in,          // Requested duty, percent
  input  wire [31:0] fm_dev_in,        // FM peak deviation, Hz
  input  wire [31:0] hop_in,           // FSK hop frequency, Hz
  input  wire [31:0] sweep_start_in,   // Sweep start frequency, Hz
  output reg         trig_fire_out,    // Accepted trigger pulse
  output reg  [31:0] freq_out,         // Adjusted frequency
  output reg  [6:0]  duty_out,         // Adjusted duty
  output reg  [31:0] fm_dev_out,       // Adjusted deviation
  output reg  [31:0] hop_out,          // Adjusted hop frequency
  output reg  [31:0] sweep_start_out,  // Adjusted sweep start
  output reg         reply_valid_out,  // Reply code valid pulse
  output reg  [15:0] reply_code_out,   // Signed reply code
  output reg  [6:0]  reply_msg_len_out,// Message length, chars
  output reg  [5:0]  pending_out       // Entries queued
);
  // ==========================================
  // Event gathering: up to four codes per cycle serialised
  localparam S_IDLE = 1'b0;
  localparam S_DRAIN = 1'b1;

  reg  [15:0] ev_code_q [0:3];
  reg  [3:0]  ev_pend_q;
  reg  [15:0] ev_d [0:3];
  reg  [3:0]  ev_hit_d;
  reg  [1:0]  sel_d;
  reg         have_d;
  reg  [15:0] push_code;
  reg  [31:0] fmax;
  reg  [6:0]  dmin;
  reg  [6:0]  dmax;
  reg  [31:0] fclamp;
  reg  [2:0]  set_n_d;
  reg  [2:0]  set_n_q;
  wire [15:0] head;
  wire [5:0]  count;
  wire        clr;

  // Queue emptied by clear-status only; reset command leaves it
  assign clr = clear_status_in;

  // Map fault class to its code
  function [15:0] class_code;
    input [4:0] c;
    input [3:0] s;
    begin
      case (c)
        `FC_INVALID_CHAR:  class_code = `EC_INVALID_CHAR;
        `FC_SYNTAX:        class_code = `EC_SYNTAX;
        `FC_SEPARATOR:     class_code = `EC_SEPARATOR;
        `FC_PARAM_EXTRA:   class_code = `EC_PARAM_EXTRA;
        `FC_PARAM_MISSING: class_code = `EC_PARAM_MISSING;
        `FC_UNDEF_HEADER:  class_code = `EC_UNDEF_HEADER;
        `FC_NUM_CHAR:      class_code = `EC_NUM_CHAR;
        `FC_NUM_NOT_OK:    class_code = `EC_NUM_NOT_OK;
        `FC_SUFFIX_BAD:    class_code = `EC_SUFFIX_BAD;
        `FC_SUFFIX_NOT_OK: class_code = `EC_SUFFIX_NOT_OK;
        `FC_CHAR_NOT_OK:   class_code = `EC_CHAR_NOT_OK;
        `FC_STR_NOT_OK:    class_code = `EC_STR_NOT_OK;
        `FC_EXPRESSION:    class_code = `EC_EXPR_FIRST - {12'h000, (s > 4'h8) ? 4'h8 : s};
        default:           class_code = `EC_SYNTAX;
      endcase
    end
  endfunction

  // Ceiling frequency of a function
  function [31:0] func_max;
    input [1:0] f;
    begin
      if (f == `FUNC_TRI_RAMP)
        func_max = `FMAX_TRI_RAMP;
      else if (f == `FUNC_ARB)
        func_max = `FMAX_ARB;
      else
        func_max = `FMAX_SINE_SQ;
    end
  endfunction

  // Message length reported with each code
  function [6:0] msg_len;
    input [15:0] c;
    begin
      if (c == `EC_NO_ERROR)
        msg_len = 7'h08;
      else if (c == `EC_TOO_MANY)
        msg_len = 7'h0F;
      else if (c == `EC_SETTINGS)
        msg_len = 7'h2F;
      else
        msg_len = 7'h14;
    end
  endfunction

  // ==========================================
  // Fault detection, one slot per source group
  always @* begin
    fmax = func_max(func_in);
    fclamp = (freq_in > fmax) ? fmax : freq_in;
    ev_hit_d = 4'h0;
    ev_d[0] = 16'h0000;
    ev_d[1] = 16'h0000;
    ev_d[2] = 16'h0000;
    ev_d[3] = 16'h0000;
    if (fault_in) begin
      ev_hit_d[0] = 1'b1;
      ev_d[0] = class_code(fault_class_in, expr_sub_in);
    end else if (hdr_chk_in && kw_len_in > `LIM_MNEM_CHARS) begin
      ev_hit_d[0] = 1'b1;
      ev_d[0] = `EC_MNEM_LONG;
    end else if (hdr_chk_in && !kw_known_in) begin
      ev_hit_d[0] = 1'b1;
      ev_d[0] = `EC_UNDEF_HEADER;
    end
    if (num_chk_in && exp_mag_in > `LIM_EXPONENT) begin
      ev_hit_d[1] = 1'b1;
      ev_d[1] = `EC_EXP_LARGE;
    end else if (num_chk_in && digits_in > `LIM_DIGITS) begin
      ev_hit_d[1] = 1'b1;
      ev_d[1] = `EC_DIGITS;
    end else if (par_chk_in && par_got_in > par_max_in) begin
      ev_hit_d[1] = 1'b1;
      ev_d[1] = `EC_PARAM_EXTRA;
    end else if (par_chk_in && par_got_in < par_min_in) begin
      ev_hit_d[1] = 1'b1;
      ev_d[1] = `EC_PARAM_MISSING;
    end
    if (blk_end_in && (blk_definite_in ? (blk_got_in != blk_decl_in) : !blk_eoi_nl_in)) begin
      ev_hit_d[2] = 1'b1;
      ev_d[2] = `EC_BLOCK_BAD;
    end else if (trig_in && !trig_bus_sel_in) begin
      ev_hit_d[2] = 1'b1;
      ev_d[2] = `EC_TRIG_IGNORED;
    end
    // One settings conflict entry for every item that gets adjusted; duty is counted only when square is selected
    set_n_d = {2'b00, freq_in > fmax} + {2'b00, hop_in > fmax} + {2'b00, sweep_start_in > fmax} +
              {2'b00, {1'b0, fclamp} + {1'b0, fm_dev_in} > {1'b0, fmax} + {1'b0, `FM_MARGIN}} +
              {2'b00, func_in == `FUNC_SQUARE && (duty_in < dmin || duty_in > dmax)};
    // Settings conflicts share one slot, drained once per owed entry
    if (set_chk_in && set_n_d != 3'h0) begin
      ev_hit_d[3] = 1'b1;
      ev_d[3] = `EC_SETTINGS;
    end
  end

  // Duty window depends on the adjusted frequency
  always @* begin
    if (((freq_in > fmax) ? fmax : freq_in) > `DUTY_SPLIT_HZ) begin
      dmin = `DUTY_HI_MIN;
      dmax = `DUTY_HI_MAX;
    end else begin
      dmin = `DUTY_LO_MIN;
      dmax = `DUTY_LO_MAX;
    end
  end

  // Lowest-numbered pending slot goes first
  always @* begin
    have_d = |ev_pend_q;
    if (ev_pend_q[0])
      sel_d = 2'd0;
    else if (ev_pend_q[1])
      sel_d = 2'd1;
    else if (ev_pend_q[2])
      sel_d = 2'd2;
    else
      sel_d = 2'd3;
    push_code = ev_code_q[sel_d];
  end

  // ==========================================
  // Pending event latches; a new event wins over the drain clear
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ev_pend_q    <= 4'h0;
      ev_code_q[0] <= 16'h0000;
      ev_code_q[1] <= 16'h0000;
      ev_code_q[2] <= 16'h0000;
      ev_code_q[3] <= 16'h0000;
      set_n_q      <= 3'h0;
    end else begin
      if (have_d)
        ev_pend_q[sel_d] <= 1'b0;
      // Settings slot stays pending while more conflict entries are owed
      if (have_d && sel_d == 2'h3 && set_n_q > 3'h1)
        ev_pend_q[3] <= 1'b1;
      if (have_d && sel_d == 2'h3)
        set_n_q <= set_n_q - 3'h1;
      if (ev_hit_d[0]) begin
        ev_pend_q[0] <= 1'b1;
        ev_code_q[0] <= ev_d[0];
      end
      if (ev_hit_d[1]) begin
        ev_pend_q[1] <= 1'b1;
        ev_code_q[1] <= ev_d[1];
      end
      if (ev_hit_d[2]) begin
        ev_pend_q[2] <= 1'b1;
        ev_code_q[2] <= ev_d[2];
      end
      if (ev_hit_d[3]) begin
        ev_pend_q[3] <= 1'b1;
        ev_code_q[3] <= ev_d[3];
        set_n_q      <= set_n_d;
      end
    end
  end

  // ==========================================
  // Error queue
  err_fifo u_fifo (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .clr_in    (clr),
    .push_in   (have_d),
    .code_in   (push_code),
    .pop_in    (query_in && !clr),
    .head_out  (head),
    .count_out (count),
    .full_out  ()
  );

  // ==========================================
  // Query reply: code and message length, one pulse
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reply_valid_out   <= 1'b0;
      reply_code_out    <= 16'h0000;
      reply_msg_len_out <= 7'h00;
      pending_out       <= 6'h00;
    end else begin
      pending_out     <= count;
      reply_valid_out <= query_in;
      if (query_in) begin
        reply_code_out    <= clr ? `EC_NO_ERROR : head;
        reply_msg_len_out <= msg_len(clr ? `EC_NO_ERROR : head);
      end
    end
  end

  // ==========================================
  // Clamped settings and trigger gating
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trig_fire_out   <= 1'b0;
      freq_out        <= 32'h00000000;
      duty_out        <= 7'h00;
      fm_dev_out      <= 32'h00000000;
      hop_out         <= 32'h00000000;
      sweep_start_out <= 32'h00000000;
    end else begin
      trig_fire_out <= trig_in && trig_bus_sel_in;
      if (set_chk_in) begin
        freq_out        <= (freq_in > fmax) ? fmax : freq_in;
        hop_out         <= (hop_in > fmax) ? fmax : hop_in;
        sweep_start_out <= (sweep_start_in > fmax) ? fmax : sweep_start_in;
        duty_out        <= (duty_in < dmin) ? dmin : ((duty_in > dmax) ? dmax : duty_in);
        if ({1'b0, ((freq_in > fmax) ? fmax : freq_in)} + {1'b0, fm_dev_in} >
            {1'b0, fmax} + {1'b0, `FM_MARGIN})
          fm_dev_out <= fmax + `FM_MARGIN - ((freq_in > fmax) ? fmax : freq_in);
        else
          fm_dev_out <= fm_dev_in;
      end
    end
  end
endmodule

// ---- verilog/err_queue_regs.vh ----
`ifndef ERR_QUEUE_REGS_VH
`define ERR_QUEUE_REGS_VH
// ==========================================
// Queue geometry
`define EQ_DEPTH          20
`define EQ_PTR_W          5
`define EQ_CNT_W          5
`define EQ_CODE_W         16
`define EQ_MSG_MAX        80
// ==========================================
// Error codes (two's complement, 16 bit)
`define EC_NO_ERROR       16'h0000
`define EC_INVALID_CHAR   16'hFF9B
`define EC_SYNTAX         16'hFF9A
`define EC_SEPARATOR      16'hFF99
`define EC_PARAM_EXTRA    16'hFF94
`define EC_PARAM_MISSING  16'hFF93
`define EC_MNEM_LONG      16'hFF90
`define EC_UNDEF_HEADER   16'hFF8F
`define EC_NUM_CHAR       16'hFF87
`define EC_EXP_LARGE      16'hFF85
`define EC_DIGITS         16'hFF84
`define EC_NUM_NOT_OK     16'hFF80
`define EC_SUFFIX_BAD     16'hFF7D
`define EC_SUFFIX_NOT_OK  16'hFF76
`define EC_CHAR_NOT_OK    16'hFF6C
`define EC_STR_NOT_OK     16'hFF62
`define EC_BLOCK_BAD      16'hFF5F
`define EC_EXPR_FIRST     16'hFF56
`define EC_EXPR_LAST      16'hFF4E
`define EC_TRIG_IGNORED   16'hFF2D
`define EC_SETTINGS       16'hFF23
`define EC_TOO_MANY       16'hFEA2
// ==========================================
// Fault classes presented on fault_class_in
`define FC_INVALID_CHAR   5'h00
`define FC_SYNTAX         5'h01
`define FC_SEPARATOR      5'h02
`define FC_PARAM_EXTRA    5'h03
`define FC_PARAM_MISSING  5'h04
`define FC_UNDEF_HEADER   5'h05
`define FC_NUM_CHAR       5'h06
`define FC_NUM_NOT_OK     5'h07
`define FC_SUFFIX_BAD     5'h08
`define FC_SUFFIX_NOT_OK  5'h09
`define FC_CHAR_NOT_OK    5'h0A
`define FC_STR_NOT_OK     5'h0B
`define FC_EXPRESSION     5'h0C
// ==========================================
// Limits
`define LIM_MNEM_CHARS    8'h0C
`define LIM_EXPONENT      16'h7D00
`define LIM_DIGITS        9'h0FF
`define FUNC_SINE         2'h0
`define FUNC_SQUARE       2'h1
`define FUNC_TRI_RAMP     2'h2
`define FUNC_ARB          2'h3
// Frequencies in Hz, 32 bit; duty limits in percent, 7 bit
`define FMAX_SINE_SQ      32'h00E4E1C0
`define FMAX_TRI_RAMP     32'h000186A0
`define FMAX_ARB          32'h004C4B40
`define FM_MARGIN         32'h000186A0
`define DUTY_SPLIT_HZ     32'h004C4B40
`define DUTY_HI_MIN       7'h28
`define DUTY_HI_MAX       7'h3C
`define DUTY_LO_MIN       7'h14
`define DUTY_LO_MAX       7'h50
`endif

// ---- verilog/err_fifo.v ----
`timescale 1ns/1ps
`include "err_queue_regs.vh"
// ==========================================
// Error queue storage with overflow marker
module err_fifo (
  input  wire                  mclk_in,   // System clock
  input  wire                  rst_n_in,  // Async reset, active low
  input  wire                  clr_in,    // Empty the queue
  input  wire                  push_in,   // Log one code
  input  wire [`EQ_CODE_W-1:0] code_in,   // Code to log
  input  wire                  pop_in,    // Remove oldest entry
  output wire [`EQ_CODE_W-1:0] head_out,  // Oldest entry or zero
  output wire [`EQ_CNT_W:0]    count_out, // Entries held
  output wire                  full_out   // Overflow marker stored
);
  reg [`EQ_CODE_W-1:0] mem_q [0:`EQ_DEPTH-1];
  reg [`EQ_PTR_W-1:0]  rd_q;
  reg [`EQ_PTR_W-1:0]  wr_q;
  reg [`EQ_CNT_W:0]    cnt_q;
  reg                  ovf_q;
  wire                 empty;
  wire                 do_pop;
  wire                 do_push;
  wire [`EQ_PTR_W-1:0] last;

  // Index of the highest slot, held at pointer width
  localparam [`EQ_PTR_W-1:0] LAST_SLOT = `EQ_DEPTH - 1;

  function [`EQ_PTR_W-1:0] inc;
    input [`EQ_PTR_W-1:0] p;
    begin
      inc = (p == LAST_SLOT) ? {`EQ_PTR_W{1'b0}} : p + 1'b1;
    end
  endfunction

  function [`EQ_PTR_W-1:0] dec;
    input [`EQ_PTR_W-1:0] p;
    begin
      dec = (p == {`EQ_PTR_W{1'b0}}) ? LAST_SLOT : p - 1'b1;
    end
  endfunction

  assign empty     = (cnt_q == 0);
  assign do_pop    = pop_in && !empty;
  assign last      = dec(wr_q);
  assign do_push   = push_in && !ovf_q;
  assign head_out  = empty ? `EC_NO_ERROR : mem_q[rd_q];
  assign count_out = cnt_q;
  assign full_out  = ovf_q;

  // ==========================================
  // Pointers, count and overflow replacement
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_q  <= {`EQ_PTR_W{1'b0}};
      wr_q  <= {`EQ_PTR_W{1'b0}};
      cnt_q <= {(`EQ_CNT_W+1){1'b0}};
      ovf_q <= 1'b0;
    end else if (clr_in) begin
      rd_q  <= {`EQ_PTR_W{1'b0}};
      wr_q  <= {`EQ_PTR_W{1'b0}};
      cnt_q <= {(`EQ_CNT_W+1){1'b0}};
      ovf_q <= 1'b0;
    end else begin
      if (do_pop)
        rd_q <= inc(rd_q);
      if (do_push && (cnt_q < `EQ_DEPTH || do_pop))
        wr_q <= inc(wr_q);
      if (do_push && cnt_q == `EQ_DEPTH && !do_pop)
        ovf_q <= 1'b1;
      else if (do_pop)
        ovf_q <= 1'b0;
      if (do_push && (cnt_q < `EQ_DEPTH || do_pop) && !do_pop)
        cnt_q <= cnt_q + 1'b1;
      else if (do_pop && !(do_push))
        cnt_q <= cnt_q - 1'b1;
    end
  end

  // ==========================================
  // Storage writes; overflow overwrites newest slot
  always @(posedge mclk_in) begin
    if (!clr_in && do_push) begin
      if (cnt_q == `EQ_DEPTH && !do_pop)
        mem_q[last] <= `EC_TOO_MANY;
      else
        mem_q[wr_q] <= code_in;
    end
  end
endmodule

// ---- tb/cmd_err_checker_chk.sv ----
`timescale 1ns/1ps
`include "err_queue_regs.vh"
// ==========================================
// Port checker for the error queue block
module cmd_err_checker_chk (
  input wire        mclk_in,           // Clock
  input wire        rst_n_in,          // Reset, active low
  input wire        query_in,          // Error query
  input wire        trig_in,           // Trigger
  input wire        trig_bus_sel_in,   // Bus source selected
  input wire        set_chk_in,        // Settings changed
  input wire [1:0]  func_in,           // Function
  input wire        trig_fire_out,     // Trigger accepted
  input wire [31:0] freq_out,          // Frequency
  input wire [6:0]  duty_out,          // Duty
  input wire [31:0] fm_dev_out,        // Deviation
  input wire [31:0] hop_out,           // Hop frequency
  input wire [31:0] sweep_start_out,   // Sweep start
  input wire        reply_valid_out,   // Reply strobe
  input wire [15:0] reply_code_out,    // Reply code
  input wire [6:0]  reply_msg_len_out, // Reply length
  input wire [5:0]  pending_out        // Entries queued
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================
  // Ceiling of the function seen at the last edge
  logic [32:0] lim_q;
  always @(posedge mclk_in) begin
    lim_q <= (func_in == `FUNC_TRI_RAMP) ? `FMAX_TRI_RAMP : (func_in == `FUNC_ARB) ? `FMAX_ARB : `FMAX_SINE_SQ;
  end
  // ==========================================
  // Reply handshake
  sequence s_answer;
    ##1 reply_valid_out;
  endsequence
  sequence s_accepted;
    trig_in && trig_bus_sel_in;
  endsequence
  chk_reply_on_query: assert property (query_in |-> s_answer) else $error("no reply after query");
  chk_reply_one_shot: assert property (!query_in |=> !reply_valid_out) else $error("reply without query");
  chk_reply_code_hold: assert property (!query_in |=> $stable(reply_code_out)) else $error("reply code moved");
  chk_reply_text_len: assert property (reply_valid_out |-> reply_msg_len_out inside {[7'h01:7'h50]})
    else $error("reply text length out of range");
  chk_queue_depth_bound: assert property (pending_out <= 6'h14) else $error("queue holds more than its depth");
  // ==========================================
  // Trigger and settings
  chk_trig_fire_cause: assert property (trig_fire_out |-> $past(trig_in && trig_bus_sel_in)) else $error("trigger fired");
  chk_trig_fire_taken: assert property (s_accepted |=> trig_fire_out) else $error("accepted trigger lost");
  chk_duty_band_kept: assert property (set_chk_in && func_in == `FUNC_SQUARE |=> (freq_out > `DUTY_SPLIT_HZ) ?
    (duty_out inside {[`DUTY_HI_MIN:`DUTY_HI_MAX]}) : (duty_out inside {[`DUTY_LO_MIN:`DUTY_LO_MAX]}))
    else $error("duty outside band");
  chk_fm_dev_cap: assert property (set_chk_in |=> {1'b0, freq_out} + fm_dev_out <= lim_q + `FM_MARGIN)
    else $error("deviation above cap");
  chk_freq_ceiling_kept: assert property (set_chk_in |=> freq_out <= lim_q && hop_out <= lim_q &&
    sweep_start_out <= lim_q) else $error("frequency above ceiling");
endmodule
bind cmd_err_checker cmd_err_checker_chk chk_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .query_in(query_in),
  .trig_in(trig_in), .trig_bus_sel_in(trig_bus_sel_in), .set_chk_in(set_chk_in), .func_in(func_in),
  .trig_fire_out(trig_fire_out), .freq_out(freq_out), .duty_out(duty_out), .fm_dev_out(fm_dev_out),
  .hop_out(hop_out), .sweep_start_out(sweep_start_out), .reply_valid_out(reply_valid_out),
  .reply_code_out(reply_code_out), .reply_msg_len_out(reply_msg_len_out), .pending_out(pending_out));

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Host program that drains the queue by polling
module host_model (
  input  wire        mclk_in,        // Clock
  input  wire        reply_valid_in, // Reply strobe
  input  wire [15:0] reply_code_in,  // Reply code
  input  wire [6:0]  reply_len_in,   // Reply length
  output logic       query_out       // Query pulse
);
  initial query_out = 1'b0;
  // One query per poll; a gap makes the host slow
  task automatic poll(input int gap, output logic [15:0] code, output logic [6:0] len, output logic ok);
    repeat (gap) @(posedge mclk_in);
    @(posedge mclk_in) #1 query_out = 1'b1;
    @(posedge mclk_in) #1 query_out = 1'b0;
    ok = reply_valid_in;
    code = reply_code_in;
    len = reply_len_in;
  endtask
endmodule

// ---- tb/tb_cmd_err_checker.sv ----
`timescale 1ns/1ps
module tb_cmd_err_checker;
  // ==========================================
  // Stimulus, outputs and reference queue
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        clr = 1'b0, rcmd = 1'b0, kwk = 1'b1, bdef = 1'b1, bnl = 1'b1, tsel = 1'b1, v;
  logic [6:0]  ev = 7'h00, duty = 7'h32, l;
  logic [4:0]  fcls = 5'h00;
  logic [3:0]  sub = 4'h0, pgot = 4'h0, pmin = 4'h0, pmax = 4'h0;
  logic [7:0]  kwl = 8'h00;
  logic [15:0] expm = 16'h0000, bdecl = 16'h0000, bgot = 16'h0000, c;
  logic [8:0]  dig = 9'h000;
  logic [1:0]  func = 2'h0;
  logic [31:0] freq = 32'h0, dev = 32'h0, hop = 32'h0, swp = 32'h0;
  wire         query, fire_o, rvalid;
  wire  [31:0] freq_o, dev_o, hop_o, swp_o;
  wire  [6:0]  duty_o, rlen;
  wire  [15:0] rcode;
  wire  [5:0]  pending;
  logic [15:0] q[$];
  bit          ovf;
  int          n_fail, tests_run, fires;
  int          codes[12] = '{-101, -102, -103, -108, -109, -113, -121, -128, -131, -138, -148, -158};

  initial forever #5 mclk_in = ~mclk_in;
  // Count accepted triggers away from the active edge
  always @(negedge mclk_in) if (fire_o === 1'b1) fires++;

  cmd_err_checker cmd_err_checker_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .clear_status_in(clr),
    .reset_cmd_in(rcmd), .query_in(query), .fault_in(ev[0]), .fault_class_in(fcls), .expr_sub_in(sub),
    .hdr_chk_in(ev[1]), .kw_len_in(kwl), .kw_known_in(kwk), .num_chk_in(ev[2]), .exp_mag_in(expm),
    .digits_in(dig), .par_chk_in(ev[3]), .par_got_in(pgot), .par_min_in(pmin), .par_max_in(pmax),
    .blk_end_in(ev[4]), .blk_definite_in(bdef), .blk_decl_in(bdecl), .blk_got_in(bgot), .blk_eoi_nl_in(bnl),
    .trig_in(ev[5]), .trig_bus_sel_in(tsel), .set_chk_in(ev[6]), .func_in(func), .freq_in(freq),
    .duty_in(duty), .fm_dev_in(dev), .hop_in(hop), .sweep_start_in(swp), .trig_fire_out(fire_o),
    .freq_out(freq_o), .duty_out(duty_o), .fm_dev_out(dev_o), .hop_out(hop_o), .sweep_start_out(swp_o),
    .reply_valid_out(rvalid), .reply_code_out(rcode), .reply_msg_len_out(rlen), .pending_out(pending));
  host_model host_model_i (.mclk_in(mclk_in), .reply_valid_in(rvalid), .reply_code_in(rcode),
    .reply_len_in(rlen), .query_out(query));

  // ==========================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Reference queue: full queue marks its newest slot, then drops
  task automatic log_ref(input int code);
    if (ovf) return;
    if (q.size() < 20) q.push_back(16'(code));
    else begin
      q[19] = 16'hFEA2;
      ovf = 1'b1;
    end
  endtask
  // Pulse one event input, then compare the queue count
  task automatic fire(input int k, input int code, input int n = 1);
    @(posedge mclk_in) #1 ev[k] = 1'b1;
    @(posedge mclk_in) #1 ev = 7'h00;
    repeat (n) if (code != 0) log_ref(code);
    repeat (8) @(posedge mclk_in);
    #1 check("pending", pending, q.size());
  endtask
  task automatic drain(input int n);
    logic [15:0] e;
    repeat (n) begin
      e = (q.size() != 0) ? q.pop_front() : 16'h0000;
      ovf = 1'b0;
      host_model_i.poll($urandom_range(3), c, l, v);
      check("reply valid", v, 1);
      check("reply code", c, e);
      check("reply length", l, (e == 16'h0000) ? 8 : (e == 16'hFEA2) ? 15 : (e == 16'hFF23) ? 47 : 20);
    end
  endtask
  task automatic setting(input int f, input longint fr, dv, hp, sw, input int dt);
    longint cap, ef, ed;
    int lo, hi, edt, n;
    cap = (f == 2) ? 100000 : (f == 3) ? 5000000 : 15000000;
    ef = (fr > cap) ? cap : fr;
    lo = (ef > 5000000) ? 40 : 20;
    hi = (ef > 5000000) ? 60 : 80;
    edt = (dt < lo) ? lo : (dt > hi) ? hi : dt;
    ed = (ef + dv > cap + 100000) ? cap + 100000 - ef : dv;
    {func, freq, dev, hop, swp, duty} = {2'(f), 32'(fr), 32'(dv), 32'(hp), 32'(sw), 7'(dt)};
    n = (ef != fr) + (ed != dv) + (hp > cap) + (sw > cap) + (f == 1 && edt != dt);
    fire(6, (n != 0) ? -221 : 0, n);
    check("freq", freq_o, ef);
    check("hop", hop_o, (hp > cap) ? cap : hp);
    check("sweep", swp_o, (sw > cap) ? cap : sw);
    check("deviation", dev_o, ed);
    if (f == 1) check("duty", duty_o, edt);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================
  // Watchdog
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
  // ==========================================
  // Test sequence
  initial begin
    void'($urandom(61548));
    repeat (10) @(posedge mclk_in);
    #1 rst_n_in = 1'b1;
    host_model_i.poll(0, c, l, v);
    check("empty code", c, 16'h0000);
    check("empty length", l, 7'h08);
    check("pending", pending, 0);
    $display("test power_up_empty done");
    for (int i = 0; i < 21; i++) begin
      {fcls, sub} = (i < 12) ? {5'(i), 4'h0} : {5'h0C, 4'(i - 12)};
      fire(0, (i < 12) ? codes[i] : -158 - i);
    end
    drain(21);
    $display("test fault_classes done");
    for (int i = 0; i < 23; i++) begin
      fcls = 5'($urandom_range(11));
      fire(0, codes[fcls]);
    end
    drain(1);
    fcls = 5'h00;
    fire(0, codes[0]);
    drain(21);
    $display("test overflow done");
    {kwl, kwk} = {8'h0D, 1'b1};
    fire(1, -112);
    {kwl, kwk} = {8'h0C, 1'b0};
    fire(1, -113);
    kwk = 1'b1;
    fire(1, 0);
    {expm, dig} = {16'h7D01, 9'h000};
    fire(2, -123);
    {expm, dig} = {16'h7D00, 9'h0FF};
    fire(2, 0);
    dig = 9'h100;
    fire(2, -124);
    {pgot, pmin, pmax} = {4'h3, 4'h1, 4'h2};
    fire(3, -108);
    pgot = 4'h0;
    fire(3, -109);
    pgot = 4'h2;
    fire(3, 0);
    {bdef, bdecl, bgot} = {1'b1, 16'h0064, 16'h0063};
    fire(4, -161);
    bgot = 16'h0064;
    fire(4, 0);
    {bdef, bnl} = 2'b00;
    fire(4, -161);
    bnl = 1'b1;
    fire(4, 0);
    tsel = 1'b0;
    fire(5, -211);
    check("fires", fires, 0);
    tsel = 1'b1;
    fire(5, 0);
    check("fires", fires, 1);
    @(posedge mclk_in) #1 rcmd = 1'b1;
    @(posedge mclk_in) #1 rcmd = 1'b0;
    fcls = 5'h01;
    fire(0, codes[1]);
    drain(q.size() + 1);
    $display("test field_checks done");
    setting(2, 1000000, 0, 1000000, 200000, 50);
    setting(1, 8000000, 0, 0, 0, 70);
    setting(0, 15000000, 1000000, 0, 0, 50);
    for (int i = 0; i < 8; i++) begin
      setting($urandom_range(3), $urandom_range(16000000), $urandom_range(2000000), $urandom_range(16000000),
        $urandom_range(16000000), $urandom_range(90, 10));
    end
    drain(q.size() + 1);
    $display("test settings done");
    fcls = 5'h02;
    fire(0, codes[2]);
    fcls = 5'h03;
    fire(0, codes[3]);
    @(posedge mclk_in) #1 clr = 1'b1;
    @(posedge mclk_in) #1 clr = 1'b0;
    q.delete();
    repeat (3) @(posedge mclk_in);
    #1 check("pending", pending, 0);
    drain(1);
    $display("test clear_status done");
    complete_run();
  end
endmodule
